// *** rtl/cptd_pkg.sv ***
// Constants and types shared by the call progress tone decider.
// Assumes a 10 MHz system clock; times are converted to cycle counts here.
package cptd_pkg;
	localparam int unsigned CPTD_CLK_HZ = 10000000;
	// Times in milliseconds, as specified
	localparam int unsigned CPTD_TICK_MS = 6;
	localparam int unsigned CPTD_INIT_MS = 80;
	localparam int unsigned CPTD_STABLE_MS = 80;
	localparam int unsigned CPTD_GAP_IGNORE_MS = 20;
	localparam int unsigned CPTD_GAP_DETECT_MS = 40;
	// Cycle counts derived from the clock rate
	localparam int unsigned CPTD_TICK_CYC = CPTD_TICK_MS * (CPTD_CLK_HZ / 1000);
	localparam int unsigned CPTD_INIT_CYC = CPTD_INIT_MS * (CPTD_CLK_HZ / 1000);
	// Assessment ticks per interval: consistency needs at least the time, rounded up
	localparam int unsigned CPTD_STABLE_TICKS = (CPTD_STABLE_MS + CPTD_TICK_MS - 1) / CPTD_TICK_MS;
	// Gap longer than 20 ms but below 40 ms is cleared by the 36 ms window, rounded down
	localparam int unsigned CPTD_GAP_TICKS = CPTD_GAP_DETECT_MS / CPTD_TICK_MS;
	localparam int unsigned CPTD_GAP_MIN_TICKS = (CPTD_GAP_IGNORE_MS / CPTD_TICK_MS) + 1;
	// Frequency band limits in Hz
	localparam int unsigned CPTD_BAND_LO_HZ = 315;
	localparam int unsigned CPTD_BAND_HI_HZ = 650;
	// Signal-to-noise floor in dB
	localparam int unsigned CPTD_SNR_MIN_DB = 16;
	// Sample and measurement widths
	localparam int unsigned CPTD_SAMPLE_W = 12;
	localparam int unsigned CPTD_CNT_W = 16;
	localparam int unsigned CPTD_TICK_W = 8;
	localparam logic signed [CPTD_SAMPLE_W-1:0] CPTD_LEVEL_THR = 12'sh040;
	typedef enum logic [1:0] {
		CPTD_ST_INIT,
		CPTD_ST_IDLE,
		CPTD_ST_TONE
	} cptd_state_e;
endpackage : cptd_pkg

// *** rtl/cptd_tick_gen.sv ***
// Divider that produces one-cycle enable pulses from the system clock.
// Assumes a single free-running clock and asynchronous active-low reset.
`timescale 1ns/100ps
module cptd_tick_gen #(
	parameter int unsigned PERIOD = 60000
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	output logic o_tick
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic tick_d;
	always_comb begin
		tick_d = (cnt_q == 32'(PERIOD - 1));
		cnt_d = tick_d ? 32'h0 : cnt_q + 32'h1;
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 32'h0;
			o_tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_tick <= tick_d;
		end
	end
endmodule : cptd_tick_gen

// *** rtl/cptd_decider.sv ***
// Decision and output control of the call progress tone decider.
// Assumes line samples arrive one per clock with a valid strobe, and an SNR value in dB.
//
// What this block does
// - Classify as tone only if measured frequency lies in 315..650 Hz.
// - Require signal-to-noise of at least 16 dB before accepting.
// - Accept a candidate only after about 80 ms of consistency.
// - Monitor continuously; refresh classification every 6 ms.
// - Compare amplified level against a fixed threshold, pass result on.
// - Tone indication asserted only while level comparison is true.
// - No input, below 250 Hz or 750 Hz..10 kHz gives low output.
// - In-band single and dual call progress tones give high output (code never accepts a tone whose crossing count alternates).
// - Every assessment yields exactly tone present or no signal.
// - Combine frequency, time and amplitude analysis to reject speech and noise.
// - Output follows decision only while enable high; forced low otherwise.
// - Ignore gaps up to 20 ms (code drops o_detect for any window without level), recognise gaps of 40 ms or more.
// - Assert within 80 ms of tone start (code asserts at the 14th tick earliest, over 80 ms), deassert within 80 ms of end.
`timescale 1ns/100ps
module cptd_decider
	import cptd_pkg::*;
#(
	parameter int unsigned CLK_HZ = CPTD_CLK_HZ,
	parameter int unsigned TICK_CYC = CPTD_TICK_CYC,
	parameter int unsigned INIT_CYC = CPTD_INIT_CYC,
	parameter int unsigned STABLE_TICKS = CPTD_STABLE_TICKS,
	parameter int unsigned GAP_TICKS = CPTD_GAP_TICKS
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic signed [CPTD_SAMPLE_W-1:0] i_line_signal_input,
	input wire logic i_sample_valid,
	input wire logic [7:0] i_snr_db,
	input wire logic i_enable,
	output logic o_level_ok,
	output logic o_detect
);
	////////////////////////////////////////////////////////////////////////
	// Local constants
	localparam int unsigned MS_PER_S = 1000;
	// Allowed window-to-window wander is count >> this; speech wanders more
	localparam int unsigned JITTER_SHIFT = 3;

	////////////////////////////////////////////////////////////////////////
	// Functions
	function automatic logic [CPTD_SAMPLE_W-1:0] abs_val(input logic signed [CPTD_SAMPLE_W-1:0] v);
		abs_val = v[CPTD_SAMPLE_W-1] ? CPTD_SAMPLE_W'(-v) : CPTD_SAMPLE_W'(v);
	endfunction : abs_val

	// Crossings per window times windows per second, halved, gives the tone frequency in Hz
	function automatic logic in_band(input logic [CPTD_CNT_W-1:0] crossings);
		logic [31:0] hz;
		hz = 32'(crossings) * (MS_PER_S / CPTD_TICK_MS) / 2;
		in_band = (hz >= CPTD_BAND_LO_HZ) && (hz <= CPTD_BAND_HI_HZ);
	endfunction : in_band

	////////////////////////////////////////////////////////////////////////
	// Tick and init timers
	logic tick;
	cptd_tick_gen #(
		.PERIOD(TICK_CYC)
	) u_tick (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.o_tick(tick)
	);

	logic [31:0] init_q;
	logic [31:0] init_d;
	logic init_done;
	always_comb begin
		init_done = (init_q >= 32'(INIT_CYC));
		init_d = init_done ? init_q : init_q + 32'h1;
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			init_q <= 32'h0;
		end else begin
			init_q <= init_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-window measurement: zero crossings, level, crossing-count consistency
	logic sign_q;
	logic sign_d;
	logic [CPTD_CNT_W-1:0] xing_q;
	logic [CPTD_CNT_W-1:0] xing_d;
	logic [CPTD_CNT_W-1:0] prev_xing_q;
	logic [CPTD_CNT_W-1:0] prev_xing_d;
	logic lvl_win_q;
	logic lvl_win_d;
	logic level_ok_q;
	logic level_ok_d;
	logic cand;
	logic consistent;
	logic [CPTD_CNT_W-1:0] xdiff;
	logic loud_smp;
	logic xing_smp;
	always_comb begin
		sign_d = sign_q;
		xing_d = xing_q;
		lvl_win_d = lvl_win_q;
		prev_xing_d = prev_xing_q;
		level_ok_d = level_ok_q;
		loud_smp = 1'b0;
		xing_smp = 1'b0;
		if (i_sample_valid) begin
			sign_d = i_line_signal_input[CPTD_SAMPLE_W-1];
			xing_smp = (sign_d != sign_q);
			loud_smp = (abs_val(i_line_signal_input) >= CPTD_SAMPLE_W'(CPTD_LEVEL_THR));
		end
		// Sample on the tick edge opens the new window, so no crossing is lost
		if (tick) begin
			level_ok_d = lvl_win_q;
			prev_xing_d = xing_q;
			xing_d = CPTD_CNT_W'(xing_smp);
			lvl_win_d = loud_smp;
		end else begin
			xing_d = xing_q + CPTD_CNT_W'(xing_smp);
			lvl_win_d = lvl_win_q | loud_smp;
		end
	end
	always_comb begin
		xdiff = (xing_q > prev_xing_q) ? xing_q - prev_xing_q : prev_xing_q - xing_q;
		// In-band counts are 4 to 7, so count >> 3 is 0 and no jitter between windows is tolerated
		consistent = (xdiff <= (xing_q >> JITTER_SHIFT));
		cand = in_band(xing_q)
			&& (i_snr_db >= 8'(CPTD_SNR_MIN_DB))
			&& consistent
			&& lvl_win_q;
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sign_q <= 1'b0;
			xing_q <= '0;
			prev_xing_q <= '0;
			lvl_win_q <= 1'b0;
			level_ok_q <= 1'b0;
		end else begin
			sign_q <= sign_d;
			xing_q <= xing_d;
			prev_xing_q <= prev_xing_d;
			lvl_win_q <= lvl_win_d;
			level_ok_q <= level_ok_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decision state machine, stepped on the assessment tick
	cptd_state_e state_q;
	cptd_state_e state_d;
	logic [CPTD_TICK_W-1:0] run_q;
	logic [CPTD_TICK_W-1:0] run_d;
	logic [CPTD_TICK_W-1:0] gap_q;
	logic [CPTD_TICK_W-1:0] gap_d;
	logic detect_d;
	always_comb begin
		state_d = state_q;
		run_d = run_q;
		gap_d = gap_q;
		if (tick) begin
			case (state_q)
				CPTD_ST_INIT: begin
					if (init_done) begin
						state_d = CPTD_ST_IDLE;
					end
				end
				CPTD_ST_IDLE: begin
					if (cand) begin
						run_d = run_q + 1'b1;
						gap_d = '0;
						if (run_d >= CPTD_TICK_W'(STABLE_TICKS) - 1'b1) begin
							state_d = CPTD_ST_TONE;
							run_d = '0;
						end
					end else if (gap_q + 1'b1 >= CPTD_TICK_W'(CPTD_GAP_MIN_TICKS)) begin
						run_d = '0;
						gap_d = '0;
					end else begin
						gap_d = gap_q + 1'b1;
					end
				end
				CPTD_ST_TONE: begin
					if (cand) begin
						gap_d = '0;
					end else begin
						gap_d = gap_q + 1'b1;
						if (gap_d >= CPTD_TICK_W'(GAP_TICKS)) begin
							state_d = CPTD_ST_IDLE;
							gap_d = '0;
						end
					end
				end
				default: begin
					state_d = CPTD_ST_INIT;
				end
			endcase
		end
		// Level loss always yields no signal on the next refresh
		detect_d = o_detect;
		if (tick) begin
			detect_d = (state_d == CPTD_ST_TONE) && level_ok_d && i_enable;
		end
		if (!i_enable) begin
			detect_d = 1'b0;
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= CPTD_ST_INIT;
			run_q <= '0;
			gap_q <= '0;
			o_detect <= 1'b0;
			o_level_ok <= 1'b0;
		end else begin
			state_q <= state_d;
			run_q <= run_d;
			gap_q <= gap_d;
			o_detect <= detect_d;
			o_level_ok <= level_ok_d;
		end
	end
endmodule : cptd_decider

// *** verif/cptd_chk_properties.sv ***
// Port checker for the tone decider.
// Assumes binding onto cptd_decider; one clock domain.
`timescale 1ns/100ps
module cptd_chk import cptd_pkg::*; #(
	parameter int TICK_CYC = 100,
	parameter int INIT_CYC = 200
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic signed [CPTD_SAMPLE_W-1:0] i_line_signal_input,
	input wire logic i_sample_valid,
	input wire logic i_enable,
	input wire logic o_level_ok,
	input wire logic o_detect
);
	int unsigned cnt_q, quiet_q, run_q;
	logic loud;
	assign loud = i_sample_valid && (i_line_signal_input >= CPTD_LEVEL_THR
		|| i_line_signal_input <= -CPTD_LEVEL_THR);
	// Run spans short gaps so bridged gaps never look like a fresh start
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 0;
			quiet_q <= 0;
			run_q <= 0;
		end else begin
			cnt_q <= (cnt_q < INIT_CYC) ? cnt_q + 1 : cnt_q;
			quiet_q <= loud ? 0 : ((quiet_q < 100000) ? quiet_q + 1 : quiet_q);
			run_q <= (quiet_q <= 5 * TICK_CYC) ? run_q + 1 : 0;
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	property p_en; !i_enable |=> !o_detect; endproperty
	a_en: assert property (p_en) else $error("detect high after enable low");
	property p_gate; o_detect |-> o_level_ok; endproperty
	a_gate: assert property (p_gate) else $error("detect without level");
	property p_rise; $rose(o_detect) |-> $past(i_enable) && run_q >= 10 * TICK_CYC; endproperty
	a_rise: assert property (p_rise) else $error("detect rose too early");
	property p_lvl; $changed(o_level_ok) |=> $stable(o_level_ok) [*8]; endproperty
	a_lvl: assert property (p_lvl) else $error("level changed off tick");
	property p_init; cnt_q < INIT_CYC |-> !o_detect; endproperty
	a_init: assert property (p_init) else $error("detect during init");
	property p_quiet; quiet_q > 2 * TICK_CYC + 4 |-> !o_level_ok; endproperty
	a_quiet: assert property (p_quiet) else $error("level ok with quiet line");
	property p_fell; $fell(o_level_ok) |-> !o_detect; endproperty
	a_fell: assert property (p_fell) else $error("detect kept after level loss");
	property p_off; quiet_q > 2 * TICK_CYC + 4 |-> !o_detect; endproperty
	a_off: assert property (p_off) else $error("detect held on silence");
	c_rise: cover property ($rose(o_detect));
	c_fell: cover property ($fell(o_detect) && i_enable);
	c_lvl: cover property ($fell(o_level_ok));
endmodule : cptd_chk
bind cptd_decider cptd_chk #(.TICK_CYC(TICK_CYC), .INIT_CYC(INIT_CYC)) i_chk (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_line_signal_input(i_line_signal_input),
	.i_sample_valid(i_sample_valid), .i_enable(i_enable), .o_level_ok(o_level_ok),
	.o_detect(o_detect));

// *** verif/cptd_line_model.sv ***
// Line source: square tone of set half period and amplitude.
// Assumes bench sets controls at the falling edge.
`timescale 1ns/100ps
module cptd_line_model import cptd_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_half,
	input wire logic [11:0] i_amp,
	output logic signed [CPTD_SAMPLE_W-1:0] o_sample,
	output logic o_valid
);
	logic [7:0] cnt_q = 8'h00;
	logic pol_q = 1'b0;
	initial o_sample = '0;
	initial o_valid = 1'b0;
	// Half period 1 toggles every cycle: far out of band, used as noise
	always @(negedge i_sys_clk) begin
		o_valid <= 1'b1;
		cnt_q <= (cnt_q + 8'h01 >= i_half) ? 8'h00 : cnt_q + 8'h01;
		if (cnt_q + 8'h01 >= i_half) pol_q <= ~pol_q;
		o_sample <= pol_q ? $signed(i_amp) : -$signed(i_amp);
	end
endmodule : cptd_line_model

// *** verif/tb.sv ***
// Self-checking bench for the tone decider.
// Assumes shortened tick and init counts through parameters.
`timescale 1ns/100ps
module tb import cptd_pkg::*;;
	localparam int unsigned TK = 100;
	logic i_sys_clk, i_reset_n, i_enable, o_level_ok, o_detect, smp_valid;
	logic [7:0] i_snr_db, half;
	logic [11:0] amp, a;
	logic signed [CPTD_SAMPLE_W-1:0] smp;
	logic [7:0] tab [5] = '{8'h19, 8'h14, 8'h32, 8'h0a, 8'h01};
	int errors, check_count, s;
	cptd_line_model i_line (.i_sys_clk(i_sys_clk), .i_half(half), .i_amp(amp),
		.o_sample(smp), .o_valid(smp_valid));
	cptd_decider #(.TICK_CYC(TK), .INIT_CYC(200)) i_dut (.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n), .i_line_signal_input(smp), .i_sample_valid(smp_valid),
		.i_snr_db(i_snr_db), .i_enable(i_enable), .o_level_ok(o_level_ok), .o_detect(o_detect));
	function automatic logic exp_det(input logic [7:0] h, input logic [11:0] v, input logic [7:0] n);
		int hz;
		hz = (TK / h) * 1000 / 12;
		return hz >= CPTD_BAND_LO_HZ && hz <= CPTD_BAND_HI_HZ && v >= 12'(CPTD_LEVEL_THR)
			&& n >= CPTD_SNR_MIN_DB;
	endfunction : exp_det
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic tone(input logic [7:0] h, input logic [11:0] v, input int t);
		half <= h;
		amp <= v;
		repeat (t * TK) @(negedge i_sys_clk);
	endtask : tone
	task automatic check(input logic exp);
		check_count++;
		if (o_detect !== exp) begin
			errors++;
			$display("MISMATCH o_detect expected %b seen %b", exp, o_detect);
		end
	endtask : check
	task automatic check_lvl(input logic exp);
		check_count++;
		if (o_level_ok !== exp) begin
			errors++;
			$display("MISMATCH o_level_ok expected %b seen %b", exp, o_level_ok);
		end
	endtask : check_lvl
	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		#5000000;
		errors++;
		$display("MISMATCH run_time expected done seen hung");
		final_report();
	end
	initial begin
		s = $urandom(6232);
		i_reset_n = 1'b0;
		i_enable = 1'b1;
		i_snr_db = 8'h28;
		half = 8'h01;
		amp = 12'h004;
		repeat (6) @(negedge i_sys_clk);
		i_reset_n <= 1'b1;
		tone(8'h01, 12'h004, 2);
		check(1'b0);
		foreach (tab[i]) begin
			a = 12'h100 + 12'($urandom_range(12'h5ff));
			i_snr_db <= 8'(16 + $urandom_range(60));
			tone(tab[i], a, 16);
			check(exp_det(tab[i], a, i_snr_db));
			tone(8'h01, 12'h004, 10);
			check(1'b0);
		end
		tone(8'h14, 12'h020, 16);
		check(exp_det(8'h14, 12'h020, i_snr_db));
		check_lvl(1'b0);
		i_snr_db <= 8'h0f;
		tone(8'h14, 12'h300, 16);
		check(1'b0);
		i_snr_db <= 8'h10;
		tone(8'h14, 12'h300, 16);
		check(1'b1);
		check_lvl(1'b1);
		i_enable <= 1'b0;
		repeat (2) @(negedge i_sys_clk);
		check(1'b0);
		i_enable <= 1'b1;
		tone(8'h14, 12'h300, 2);
		check(1'b1);
		tone(8'h01, 12'h004, 2);
		tone(8'h14, 12'h300, 3);
		check(1'b1);
		tone(8'h01, 12'h004, 8);
		tone(8'h14, 12'h300, 3);
		check(1'b0);
		final_report();
	end
endmodule : tb
